// ### lsma_alu.sv
`timescale 1ns/1ns
// Data-processing datapath with registered result and flags
module lsma_alu
  import lsma_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Instruction
  input wire logic valid_i,
  input wire lsma_pkg::lsma_op_t op_i,
  input wire logic [3:0] dst_reg_i,
  input wire logic [3:0] first_src_reg_i,
  input wire logic [3:0] second_src_reg_i,
  input wire logic [3:0] shift_amount_reg_i,
  input wire logic use_imm_i,
  input wire logic [7:0] imm_i,
  input wire logic set_flags_i,
  // Operand values
  input wire logic [31:0] first_src_val_i,
  input wire logic [31:0] second_src_val_i,
  input wire logic [31:0] shift_amount_val_i,
  // Results
  output logic [31:0] result_o,
  output logic [3:0] wr_reg_o,
  output logic wr_en_o,
  output logic branch_o,
  output logic [31:0] branch_addr_o,
  output logic [3:0] flags_o,
  output logic illegal_o,
  output logic done_o
);
  import lsma_pkg::*;

  function automatic logic is_low(input logic [3:0] r);
    is_low = (r <= LSMA_LOW_REG_MAX);
  endfunction

  function automatic logic [31:0] bswap16(input logic [31:0] v);
    bswap16 = {v[23:16], v[31:24], v[7:0], v[15:8]};
  endfunction

  logic [31:0] result_d, result_q;
  logic [31:0] addr_d, addr_q;
  logic [3:0] wr_reg_d, wr_reg_q;
  logic [3:0] flags_d, flags_q;
  logic wr_en_d, wr_en_q, branch_d, branch_q, illegal_d, illegal_q, done_d, done_q;

  logic [31:0] b_val;
  logic [7:0] sh_cnt;
  logic [31:0] sh_res;
  logic sh_c;
  logic [32:0] sum;
  logic [31:0] prod;
  logic [31:0] r;
  logic legal, wr, nz, cv, c_new, v_new;

  ////////////////////////////////////////////////////////////////
  // Operand selection
  always_comb
  begin
    b_val = use_imm_i ? {24'h0, imm_i} : second_src_val_i;
    // Immediate zero means a full 32-place shift for the right shifts
    if (use_imm_i)
      sh_cnt = (imm_i == 8'h00 && op_i != logic_shift_left) ? 8'(LSMA_SH_FULL) : imm_i;
    else
      sh_cnt = shift_amount_val_i[7:0];
  end

  lsma_shifter u_shifter (
    .value_i(second_src_val_i),
    .count_i(sh_cnt),
    .kind_i(op_i),
    .carry_i(flags_q[LSMA_FLAG_C]),
    .result_o(sh_res),
    .carry_o(sh_c)
  );

  assign prod = first_src_val_i * second_src_val_i;

  ////////////////////////////////////////////////////////////////
  // Execute
  always_comb
  begin
    r = LSMA_WORD_ZERO;
    sum = 33'h0;
    legal = 1'b1;
    wr = 1'b1;
    nz = 1'b0;
    cv = 1'b0;
    c_new = flags_q[LSMA_FLAG_C];
    v_new = flags_q[LSMA_FLAG_V];
    unique case (op_i)
      and_set_flags, xor_set_flags, or_set_flags, bit_clear_set_flags:
      begin
        unique case (op_i)
          and_set_flags: r = first_src_val_i & second_src_val_i;
          xor_set_flags: r = first_src_val_i ^ second_src_val_i;
          or_set_flags: r = first_src_val_i | second_src_val_i;
          default: r = first_src_val_i & ~second_src_val_i;
        endcase
        nz = 1'b1;
        legal = is_low(dst_reg_i) && is_low(second_src_reg_i)
          && dst_reg_i == first_src_reg_i;
      end
      arith_shift_right, logic_shift_left, logic_shift_right, rotate_right:
      begin
        r = sh_res;
        nz = 1'b1;
        c_new = sh_c;
        legal = is_low(dst_reg_i) && is_low(second_src_reg_i)
          && (use_imm_i ? (op_i != rotate_right && (op_i != logic_shift_left
          || imm_i[5:0] <= LSMA_IMM_MAX_LEFT) && imm_i <= 8'(LSMA_SH_FULL))
          : (is_low(shift_amount_reg_i) && dst_reg_i == second_src_reg_i));
      end
      compare_op:
      begin
        sum = {1'b0, first_src_val_i} + {1'b0, ~b_val} + 33'h1;
        r = sum[31:0];
        wr = 1'b0;
        nz = 1'b1;
        cv = 1'b1;
        c_new = sum[32];
        v_new = (first_src_val_i[31] != b_val[31]) && (r[31] != first_src_val_i[31]);
        legal = first_src_reg_i <= LSMA_CMP_REG_MAX
          && (use_imm_i || second_src_reg_i <= LSMA_CMP_REG_MAX);
      end
      compare_negative_op:
      begin
        sum = {1'b0, first_src_val_i} + {1'b0, second_src_val_i};
        r = sum[31:0];
        wr = 1'b0;
        nz = 1'b1;
        cv = 1'b1;
        c_new = sum[32];
        v_new = (first_src_val_i[31] == second_src_val_i[31])
          && (r[31] != first_src_val_i[31]);
        legal = is_low(first_src_reg_i) && is_low(second_src_reg_i);
      end
      move_op, move_set_flags:
      begin
        r = (op_i == move_set_flags && use_imm_i) ? {24'h0, imm_i} : second_src_val_i;
        nz = (op_i == move_set_flags);
        legal = (op_i == move_op) || (is_low(dst_reg_i) && is_low(second_src_reg_i));
      end
      move_inverted:
      begin
        r = ~second_src_val_i;
        nz = 1'b1;
        legal = is_low(dst_reg_i) && is_low(second_src_reg_i);
      end
      multiply_low_word:
      begin
        r = prod;
        nz = 1'b1;
        legal = is_low(dst_reg_i) && is_low(first_src_reg_i)
          && dst_reg_i == second_src_reg_i;
      end
      byte_reverse_word, byte_reverse_halves, byte_reverse_signed_half:
      begin
        if (op_i == byte_reverse_word)
          r = {second_src_val_i[7:0], second_src_val_i[15:8],
            second_src_val_i[23:16], second_src_val_i[31:24]};
        else if (op_i == byte_reverse_halves)
          r = bswap16(second_src_val_i);
        else
          r = {{16{second_src_val_i[7]}}, second_src_val_i[7:0],
            second_src_val_i[15:8]};
        legal = is_low(dst_reg_i) && is_low(second_src_reg_i);
      end
      sign_extend_byte, sign_extend_half, zero_extend_byte, zero_extend_half:
      begin
        unique case (op_i)
          sign_extend_byte: r = {{24{second_src_val_i[7]}}, second_src_val_i[7:0]};
          sign_extend_half: r = {{16{second_src_val_i[15]}}, second_src_val_i[15:0]};
          zero_extend_byte: r = {24'h0, second_src_val_i[7:0]};
          default: r = {16'h0, second_src_val_i[15:0]};
        endcase
        legal = is_low(dst_reg_i) && is_low(second_src_reg_i);
      end
      bit_test_op:
      begin
        r = first_src_val_i & second_src_val_i;
        wr = 1'b0;
        nz = 1'b1;
        legal = is_low(first_src_reg_i) && is_low(second_src_reg_i);
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    result_d = result_q;
    addr_d = addr_q;
    wr_reg_d = wr_reg_q;
    flags_d = flags_q;
    wr_en_d = 1'b0;
    branch_d = 1'b0;
    illegal_d = 1'b0;
    done_d = 1'b0;
    if (valid_i)
    begin
      done_d = 1'b1;
      illegal_d = ~legal;
      if (legal)
      begin
        result_d = r;
        if (wr && op_i == move_op && dst_reg_i == LSMA_PC_REG)
        begin
          branch_d = 1'b1;
          addr_d = {r[31:1], 1'b0};
        end
        else
        begin
          wr_en_d = wr;
          wr_reg_d = dst_reg_i;
        end
        if (nz && (op_i != move_set_flags || set_flags_i || 1'b1))
        begin
          flags_d[LSMA_FLAG_N] = r[31];
          flags_d[LSMA_FLAG_Z] = (r == LSMA_WORD_ZERO);
          flags_d[LSMA_FLAG_C] = c_new;
          if (cv)
            flags_d[LSMA_FLAG_V] = v_new;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_q <= LSMA_WORD_ZERO;
      addr_q <= LSMA_WORD_ZERO;
      wr_reg_q <= 4'h0;
      flags_q <= LSMA_FLAGS_RST;
      wr_en_q <= 1'b0;
      branch_q <= 1'b0;
      illegal_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      result_q <= result_d;
      addr_q <= addr_d;
      wr_reg_q <= wr_reg_d;
      flags_q <= flags_d;
      wr_en_q <= wr_en_d;
      branch_q <= branch_d;
      illegal_q <= illegal_d;
      done_q <= done_d;
    end
  end

  assign result_o = result_q;
  assign wr_reg_o = wr_reg_q;
  assign wr_en_o = wr_en_q;
  assign branch_o = branch_q;
  assign branch_addr_o = addr_q;
  assign flags_o = flags_q;
  assign illegal_o = illegal_q;
  assign done_o = done_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_logic_op;
    valid_i && legal && op_i inside {and_set_flags, xor_set_flags, or_set_flags,
      bit_clear_set_flags, bit_test_op};
  endsequence

  AST_LOGIC_KEEPS_CV: assert property (s_logic_op |=> flags_o[1:0] == $past(flags_o[1:0]))
    else $error("Logic op changed C or V");
  AST_AND_RESULT: assert property (valid_i && legal && op_i == and_set_flags
    |=> result_o == $past(first_src_val_i & second_src_val_i) && wr_en_o)
    else $error("AND result wrong");
  AST_BIC_RESULT: assert property (valid_i && legal && op_i == bit_clear_set_flags
    |=> result_o == $past(first_src_val_i & ~second_src_val_i))
    else $error("Bit clear result wrong");
  AST_LOGIC_REGS: assert property (valid_i && op_i == and_set_flags
    && dst_reg_i != first_src_reg_i |=> illegal_o && !wr_en_o)
    else $error("Bad logic registers accepted");
  AST_SHIFT_ZERO_C: assert property (valid_i && legal && op_i == logic_shift_left
    && use_imm_i && imm_i == 8'h00 |=> flags_o[LSMA_FLAG_C] == $past(flags_o[LSMA_FLAG_C]))
    else $error("Zero shift changed carry");
  AST_CMP_NO_WRITE: assert property (valid_i && op_i inside {compare_op, compare_negative_op,
    bit_test_op} |=> !wr_en_o && done_o)
    else $error("Compare wrote a register");
  AST_MUL_V: assert property (valid_i && legal && op_i == multiply_low_word
    |=> flags_o[LSMA_FLAG_V] == $past(flags_o[LSMA_FLAG_V])
    && result_o == $past(prod))
    else $error("Multiply wrong");
  AST_PC_BRANCH: assert property (branch_o |-> !branch_addr_o[0] && !wr_en_o)
    else $error("Branch address bit 0 set");
  AST_EXT_FLAGS: assert property (valid_i && op_i inside {sign_extend_byte, zero_extend_half,
    byte_reverse_word} |=> $stable(flags_o))
    else $error("Extend changed flags");
  AST_ZERO_FLAG: assert property (done_o && !illegal_o && $past(nz)
    |-> flags_o[LSMA_FLAG_Z] == (result_o == LSMA_WORD_ZERO))
    else $error("Zero flag mismatch");
endmodule // lsma_alu

// ### lsma_pkg.sv
// Constants and types of the logic, shift and move datapath
//
// Behaviour
// - Logic unit gives AND, XOR or OR of the two sources per opcode.
// - Bit-clear And_set_flags first operand with inverse of second operand.
// - Four logic operations set N and Z, keep C and V.
// - Logic operations use low eight registers; destination equals first source.
// - Shift count from immediate or low byte of count register; four shift kinds.
// - Immediate counts: arith right 1-32, left 0-31, logic right 1-32.
// - Shifts set N, Z, C gets last bit out; C kept at count zero.
// - Shifts use low eight registers; register-count form needs destination equal source.
// - Flag-setting low register move runs as left shift by zero.
// - Compare subtracts register or immediate, sets flags like subtract, no write.
// - Compare-negative adds registers, sets flags like add, low registers only.
// - Register compare accepts registers 0 to 14; immediate compare 0 to 255.
// - Both compares update N, Z, C and V.
// - Move copies source; flag move may load immediate 0-255, sets N and Z.
// - Move-inverted writes complement of source and sets N and Z.
// - Move to program counter branches with bit 0 cleared; state bit kept.
// - Multiply keeps low 32 bits of product, same signed or unsigned.
// - Multiply low registers, destination equals second source, sets N and Z only.
// - Full byte reversal swaps four bytes, flags unchanged.
// - Half reversal swaps bytes per half; signed form sign-extends low half.
// - Extends take byte or half, sign or zero extend, flags unchanged.
package lsma_pkg;
  localparam int unsigned LSMA_DW = 32;
  localparam int unsigned LSMA_RW = 4;
  localparam logic [3:0] LSMA_LOW_REG_MAX = 4'h7;
  localparam logic [3:0] LSMA_CMP_REG_MAX = 4'he;
  localparam logic [3:0] LSMA_PC_REG = 4'hf;
  localparam logic [5:0] LSMA_SH_FULL = 6'h20;
  localparam logic [5:0] LSMA_IMM_MAX_LEFT = 6'h1f;
  localparam logic [31:0] LSMA_WORD_ZERO = 32'h0000_0000;
  localparam logic [3:0] LSMA_FLAGS_RST = 4'h0;
  localparam int unsigned LSMA_FLAG_N = 3;
  localparam int unsigned LSMA_FLAG_Z = 2;
  localparam int unsigned LSMA_FLAG_C = 1;
  localparam int unsigned LSMA_FLAG_V = 0;

  typedef enum logic [4:0] {
    and_set_flags = 5'h00,
    xor_set_flags = 5'h01,
    or_set_flags = 5'h02,
    bit_clear_set_flags = 5'h03,
    arith_shift_right = 5'h04,
    logic_shift_left = 5'h05,
    logic_shift_right = 5'h06,
    rotate_right = 5'h07,
    compare_op = 5'h08,
    compare_negative_op = 5'h09,
    move_op = 5'h0a,
    move_set_flags = 5'h0b,
    move_inverted = 5'h0c,
    multiply_low_word = 5'h0d,
    byte_reverse_word = 5'h0e,
    byte_reverse_halves = 5'h0f,
    byte_reverse_signed_half = 5'h10,
    sign_extend_byte = 5'h11,
    sign_extend_half = 5'h12,
    zero_extend_byte = 5'h13,
    zero_extend_half = 5'h14,
    bit_test_op = 5'h15
  } lsma_op_t;
endpackage

// ### lsma_shifter.sv
`timescale 1ns/1ns
// Barrel shifter giving result and carry out
module lsma_shifter
  import lsma_pkg::*;
(
  // Operands
  input wire logic [31:0] value_i,
  input wire logic [7:0] count_i,
  input wire lsma_pkg::lsma_op_t kind_i,
  input wire logic carry_i,
  // Results
  output logic [31:0] result_o,
  output logic carry_o
);
  logic [63:0] wide;
  logic [4:0] rot;
  localparam logic [7:0] SH_FULL = 8'(LSMA_SH_FULL);

  always_comb
  begin
    wide = 64'h0;
    rot = count_i[4:0];
    result_o = value_i;
    carry_o = carry_i;
    if (count_i != 8'h00)
    begin
      unique case (kind_i)
        logic_shift_left:
        begin
          wide = {32'h0, value_i} << count_i;
          result_o = (count_i > SH_FULL) ? LSMA_WORD_ZERO : wide[31:0];
          carry_o = (count_i > SH_FULL) ? 1'b0 : wide[32];
        end
        logic_shift_right:
        begin
          wide = {value_i, 32'h0} >> count_i;
          result_o = (count_i > SH_FULL) ? LSMA_WORD_ZERO : wide[63:32];
          carry_o = (count_i > SH_FULL) ? 1'b0 : wide[31];
        end
        arith_shift_right:
        begin
          wide = 64'($signed({value_i, 32'h0}) >>> ((count_i > SH_FULL) ? SH_FULL : count_i));
          result_o = wide[63:32];
          carry_o = (count_i >= SH_FULL) ? value_i[31] : wide[31];
        end
        default:
        begin
          result_o = (value_i >> rot) | (value_i << (LSMA_SH_FULL - {1'b0, rot}));
          carry_o = result_o[31];
        end
      endcase
    end
  end
endmodule // lsma_shifter

// ### tb_logic_shift_move_alu.sv
// Self-checking bench of the logic, shift and move datapath
`timescale 1ns/1ns
module tb_logic_shift_move_alu;
  import lsma_pkg::*;
  typedef struct packed {
    logic [31:0] res;
    logic [31:0] addr;
    logic [3:0] flg;
    logic [3:0] dst;
    logic wr;
    logic ill;
    logic br;
  } lsma_exp_t;
  logic clk_sys_i, resetn_i, valid_i, use_imm_i, set_flags_i;
  lsma_op_t op_i;
  logic [3:0] dst_reg_i, first_src_reg_i, second_src_reg_i, shift_amount_reg_i;
  logic [7:0] imm_i;
  logic [31:0] first_src_val_i, second_src_val_i, shift_amount_val_i;
  logic [31:0] result_o, branch_addr_o;
  logic [3:0] wr_reg_o, flags_o;
  logic wr_en_o, branch_o, illegal_o, done_o;
  int fails, comparisons;
  lsma_exp_t exp_q[$];
  lsma_exp_t mon_e;
  logic [3:0] mflg;
  logic [31:0] mres, seed;
  lsma_alu u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .valid_i(valid_i),
    .op_i(op_i), .dst_reg_i(dst_reg_i), .first_src_reg_i(first_src_reg_i),
    .second_src_reg_i(second_src_reg_i), .shift_amount_reg_i(shift_amount_reg_i),
    .use_imm_i(use_imm_i), .imm_i(imm_i), .set_flags_i(set_flags_i),
    .first_src_val_i(first_src_val_i), .second_src_val_i(second_src_val_i),
    .shift_amount_val_i(shift_amount_val_i), .result_o(result_o), .wr_reg_o(wr_reg_o),
    .wr_en_o(wr_en_o), .branch_o(branch_o), .branch_addr_o(branch_addr_o),
    .flags_o(flags_o), .illegal_o(illegal_o), .done_o(done_o));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp32(input string w, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic cmp4(input string w, input logic [3:0] g, input logic [3:0] e);
    cmp32(w, {28'h0, g}, {28'h0, e});
  endtask
  task automatic cmp1(input string w, input logic g, input logic e);
    cmp32(w, {31'h0, g}, {31'h0, e});
  endtask
  task automatic test_done();
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Model one op, note the expectation, then drive it
  task automatic issue(input lsma_op_t op, input logic [15:0] rg, input logic ui,
      input logic [7:0] im, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] sv, input logic bad);
    lsma_exp_t e;
    logic [31:0] r, o;
    logic [32:0] t;
    logic [63:0] w;
    logic [7:0] n;
    logic c, v, nz, sb;
    c = mflg[1];
    v = mflg[0];
    nz = 1'b1;
    e = '0;
    e.wr = 1'b1;
    e.dst = rg[15:12];
    n = ui ? im : sv[7:0];
    if (ui && n == 8'h00 && op != logic_shift_left)
      n = 8'h20;
    case (op)
      and_set_flags: r = a & b;
      xor_set_flags: r = a ^ b;
      or_set_flags: r = a | b;
      bit_clear_set_flags: r = a & ~b;
      bit_test_op:
      begin
        r = a & b;
        e.wr = 1'b0;
      end
      compare_op, compare_negative_op:
      begin
        sb = (op == compare_op);
        o = (sb && ui) ? {24'h0, im} : b;
        o = sb ? ~o : o;
        t = {1'b0, a} + {1'b0, o} + {32'h0, sb};
        r = t[31:0];
        c = t[32];
        v = (a[31] == o[31]) && (r[31] != a[31]);
        e.wr = 1'b0;
      end
      move_op:
      begin
        r = b;
        nz = 1'b0;
        if (rg[15:12] == 4'hf)
        begin
          e.br = 1'b1;
          e.wr = 1'b0;
          e.addr = {b[31:1], 1'b0};
        end
      end
      move_set_flags: r = ui ? {24'h0, im} : b;
      move_inverted: r = ~b;
      multiply_low_word: r = a * b;
      default:
      begin
        nz = !(op inside {byte_reverse_word, byte_reverse_halves, byte_reverse_signed_half,
          sign_extend_byte, sign_extend_half, zero_extend_byte, zero_extend_half});
        r = b;
        case (op)
          byte_reverse_word: r = {b[7:0], b[15:8], b[23:16], b[31:24]};
          byte_reverse_halves: r = {b[23:16], b[31:24], b[7:0], b[15:8]};
          byte_reverse_signed_half: r = {{16{b[7]}}, b[7:0], b[15:8]};
          sign_extend_byte: r = {{24{b[7]}}, b[7:0]};
          sign_extend_half: r = {{16{b[15]}}, b[15:0]};
          zero_extend_byte: r = {24'h0, b[7:0]};
          zero_extend_half: r = {16'h0, b[15:0]};
          default:
          begin
            case (op)
              logic_shift_left: w = {32'h0, b} << n;
              logic_shift_right: w = {b, 32'h0} >> n;
              arith_shift_right: w = 64'($signed({b, 32'h0}) >>> n);
              default: w = {b, b} >> n[4:0];
            endcase
            if (n != 8'h00)
            begin
              r = (op == logic_shift_left) ? w[31:0] : (op == rotate_right) ? w[31:0] : w[63:32];
              c = (op == logic_shift_left) ? w[32] : (op == rotate_right) ? r[31] : w[31];
            end
          end
        endcase
      end
    endcase
    e.res = r;
    e.flg = nz ? {r[31], r == 32'h0, c, v} : mflg;
    if (bad)
    begin
      e.res = mres;
      e.flg = mflg;
      e.wr = 1'b0;
      e.ill = 1'b1;
      e.br = 1'b0;
    end
    mflg = e.flg;
    mres = e.res;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    valid_i <= 1'b1;
    op_i <= op;
    {dst_reg_i, first_src_reg_i, second_src_reg_i, shift_amount_reg_i} <= rg;
    use_imm_i <= ui;
    imm_i <= im;
    set_flags_i <= a[0];
    first_src_val_i <= a;
    second_src_val_i <= b;
    shift_amount_val_i <= sv;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_i)
  begin
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("[ERR] %0t unexpected done", $time);
      end
      else
      begin
        mon_e = exp_q.pop_front();
        cmp4("flags", flags_o, mon_e.flg);
        cmp1("illegal", illegal_o, mon_e.ill);
        cmp1("branch", branch_o, mon_e.br);
        if (mon_e.br === 1'b1)
          cmp32("target", branch_addr_o, mon_e.addr);
        cmp32("result", result_o, mon_e.res);
        cmp1("write", wr_en_o, mon_e.wr);
        if (mon_e.wr === 1'b1)
          cmp4("dest", wr_reg_o, mon_e.dst);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int i, j, k;
    logic [31:0] x, y;
    logic [7:0] im;
    logic ui;
    lsma_op_t op;
    logic [7:0] cnts [10] = '{0, 1, 31, 32, 33, 255, 0, 1, 31, 32};
    lsma_op_t bop [12] = '{and_set_flags, xor_set_flags, compare_op, compare_negative_op,
      multiply_low_word, rotate_right, logic_shift_right, sign_extend_byte, bit_test_op,
      move_set_flags, byte_reverse_word, logic_shift_left};
    logic [15:0] breg [12] = '{16'h1230, 16'h8830, 16'h0f10, 16'h0810, 16'h1230, 16'h3330,
      16'h4050, 16'h9090, 16'h0810, 16'h8080, 16'h1090, 16'h3038};
    seed = 32'haa35fadd;
    {valid_i, use_imm_i, set_flags_i, resetn_i} = 4'h0;
    op_i = and_set_flags;
    {dst_reg_i, first_src_reg_i, second_src_reg_i, shift_amount_reg_i, imm_i} = 24'h0;
    {first_src_val_i, second_src_val_i, shift_amount_val_i} = 96'h0;
    mflg = 4'h0;
    mres = 32'h0;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(negedge clk_sys_i);
    cmp4("reset flags", flags_o, 4'h0);
    // Every opcode with random operands, back to back
    for (i = 0; i < 176; i++)
    begin
      op = lsma_op_t'(i % 22);
      x = rnd();
      y = rnd();
      ui = (op inside {arith_shift_right, logic_shift_left, logic_shift_right, compare_op,
        move_set_flags}) ? x[8] : 1'b0;
      im = (op == logic_shift_left) ? {3'h0, x[20:16]} : (op inside {arith_shift_right,
        logic_shift_right}) ? x[23:16] % 8'd33 : x[23:16];
      issue(op, {4{1'b0, x[2:0]}}, ui, im, rnd(), y, {x[31:8], y[7:0] % 8'd41}, 1'b0);
    end
    // Count boundaries, carry primed before count zero
    for (i = 0; i < 4; i++)
      for (j = 0; j < 10; j++)
      begin
        op = lsma_op_t'(4 + i);
        ui = (j >= 6);
        if (ui && (op == rotate_right || (op == logic_shift_left && cnts[j] > 8'd31)))
          continue;
        if (j == 0)
          issue(compare_op, 16'h1110, 1'b0, 8'h0, 32'h5, 32'h5, 32'h0, 1'b0);
        issue(op, 16'h2220, ui, cnts[j], rnd(), rnd(), {24'hc3a5f0, cnts[j]}, 1'b0);
      end
    issue(compare_op, 16'h0ee0, 1'b0, 8'h0, 32'h7fffffff, 32'hffffffff, 32'h0, 1'b0);
    issue(compare_op, 16'h0700, 1'b1, 8'hff, 32'hff, 32'h0, 32'h0, 1'b0);
    issue(compare_negative_op, 16'h0670, 1'b0, 8'h0, 32'h80000000, 32'h80000000, 32'h0,
      1'b0);
    issue(move_op, 16'hf0c0, 1'b0, 8'h0, 32'h0, 32'h08001235, 32'h0, 1'b0);
    issue(move_op, 16'ha0c0, 1'b0, 8'h0, 32'h0, 32'h80000001, 32'h0, 1'b0);
    issue(move_set_flags, 16'h3000, 1'b1, 8'h00, 32'h0, 32'h1, 32'h0, 1'b0);
    issue(move_set_flags, 16'h3030, 1'b0, 8'h0, 32'h0, 32'h80000000, 32'h0, 1'b0);
    issue(logic_shift_left, 16'h2220, 1'b1, 8'h20, 32'h0, 32'h1, 32'h0, 1'b1);
    issue(arith_shift_right, 16'h2220, 1'b1, 8'h21, 32'h0, 32'h1, 32'h0, 1'b1);
    // Register limits and immediate rotate refused without side effects
    for (k = 0; k < 12; k++)
      issue(bop[k], breg[k], k == 5, 8'h3, rnd(), rnd(), 32'h4, 1'b1);
    @(posedge clk_sys_i);
    valid_i <= 1'b0;
    for (k = 0; k < 20 && exp_q.size() > 0; k++)
      @(posedge clk_sys_i);
    if (exp_q.size() > 0)
    begin
      fails++;
      $display("[ERR] %0t missing done", $time);
    end
    test_done();
  end
endmodule // tb_logic_shift_move_alu
